/* bdfm_pkg.sv */
// constants, register map and types of the bridge driver fault monitor
package bdfm_pkg;

   // apb register byte offsets
   localparam logic [7:0] BDFM_ADDR_STATUS = 8'h00;
   localparam logic [7:0] BDFM_ADDR_INT_STAT = 8'h04;
   localparam logic [7:0] BDFM_ADDR_INT_MASK = 8'h08;
   localparam logic [7:0] BDFM_ADDR_BLANK = 8'h0C;
   localparam logic [7:0] BDFM_ADDR_CHG_TMO = 8'h10;
   localparam logic [7:0] BDFM_ADDR_GATE = 8'h14;

   // status register field positions
   localparam int BDFM_ST_SHORT_LSB = 0;
   localparam int BDFM_ST_OT = 4;
   localparam int BDFM_ST_GUV = 5;
   localparam int BDFM_ST_LUV = 6;
   localparam int BDFM_ST_BUV_LSB = 7;
   localparam int BDFM_ST_SDIS = 9;

   // interrupt status and mask layout
   localparam int BDFM_EV_W = 5;
   localparam int BDFM_EV_SHORT = 0;
   localparam int BDFM_EV_OT = 1;
   localparam int BDFM_EV_GUV = 2;
   localparam int BDFM_EV_LUV = 3;
   localparam int BDFM_EV_BUV = 4;
   localparam logic [BDFM_EV_W-1:0] BDFM_INT_STAT_RST = 5'h00;
   localparam logic [BDFM_EV_W-1:0] BDFM_INT_MASK_RST = 5'h00;
   // both supplies start in undervoltage, so no event is raised for the power-up state
   localparam logic [BDFM_EV_W-1:0] BDFM_EV_PREV_RST = 5'h0C;

   // counters for blanking and bootstrap charge timeout, in clk cycles
   localparam int BDFM_CNT_W = 16;
   localparam logic [BDFM_CNT_W-1:0] BDFM_BLANK_RST = 16'h0028;
   localparam logic [BDFM_CNT_W-1:0] BDFM_CHG_TMO_RST = 16'h00C8;

   // fet order in every 4-bit vector: {low b, low a, high b, high a}
   localparam int BDFM_NFET = 4;
   localparam int BDFM_NPH = 2;

   typedef enum logic [1:0] {
      BDFM_BOOT_IDLE,
      BDFM_BOOT_CHARGE,
      BDFM_BOOT_READY
   } bdfm_boot_state_type;

endpackage : bdfm_pkg

/* bdfm_fault_monitor.sv */
// fault monitor of a full-bridge gate driver with apb status, control and interrupt
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
module bdfm_fault_monitor
   import bdfm_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   // host side reset pin, active low
   input wire logic reset_n,
   // normal gate requests from the bridge control logic
   input wire logic [BDFM_NPH-1:0] hs_req,
   input wire logic [BDFM_NPH-1:0] ls_req,
   // comparator results
   input wire logic [BDFM_NFET-1:0] vds_over,
   input wire logic short_threshold_input,
   input wire logic gate_supply_rail_below_off,
   input wire logic gate_supply_rail_above_on,
   input wire logic logic_supply_rail_below_off,
   input wire logic logic_supply_rail_above_on,
   input wire logic overtemp_hot,
   input wire logic overtemp_recovered,
   input wire logic [BDFM_NPH-1:0] boot_above_on,
   input wire logic [BDFM_NPH-1:0] boot_below_off,
   // gate drives
   output logic [BDFM_NPH-1:0] gate_hs,
   output logic [BDFM_NPH-1:0] gate_ls,
   // open-drain fault flags
   output logic fault_flag_a_out,
   output logic fault_flag_a_oe,
   output logic fault_flag_b_out,
   output logic fault_flag_b_oe,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq
);

   function automatic logic [BDFM_CNT_W-1:0] sat_inc(input logic [BDFM_CNT_W-1:0] v);
      logic [BDFM_CNT_W-1:0] r;
      r = v;
      if (v != {BDFM_CNT_W{1'b1}}) begin
         r = v + 16'h0001;
      end
      return r;
   endfunction : sat_inc

   logic [BDFM_NPH-1:0] gate_hs_ff;
   logic [BDFM_NPH-1:0] gate_ls_ff;
   logic [BDFM_NPH-1:0] nxt_gate_hs;
   logic [BDFM_NPH-1:0] nxt_gate_ls;
   logic [BDFM_NFET-1:0] gate_on;
   logic [BDFM_CNT_W-1:0] blank_cnt_ff [BDFM_NFET];
   logic [BDFM_NFET-1:0] short_det;
   logic [BDFM_NFET-1:0] short_ff;
   logic [BDFM_NFET-1:0] short_eff;
   logic short_dis;
   logic ot_ff;
   logic guv_ff;
   logic luv_ff;
   logic luv_enter;
   logic [BDFM_NPH-1:0] buv_ff;
   logic out_dis;
   bdfm_boot_state_type boot_st_ff [BDFM_NPH];
   bdfm_boot_state_type nxt_boot_st [BDFM_NPH];
   logic [BDFM_CNT_W-1:0] chg_cnt_ff [BDFM_NPH];
   logic [BDFM_CNT_W-1:0] nxt_chg_cnt [BDFM_NPH];
   logic [BDFM_NPH-1:0] charge_req;
   logic [BDFM_NPH-1:0] boot_timeout;
   logic flag_a_high;
   logic flag_b_high;
   logic fault_flag_a_oe_ff;
   logic fault_flag_b_oe_ff;
   logic [BDFM_CNT_W-1:0] blank_ff;
   logic [BDFM_CNT_W-1:0] chg_tmo_ff;
   logic [BDFM_EV_W-1:0] int_stat_ff;
   logic [BDFM_EV_W-1:0] nxt_int_stat;
   logic [BDFM_EV_W-1:0] int_mask_ff;
   logic [BDFM_EV_W-1:0] ev_cur;
   logic [BDFM_EV_W-1:0] ev_prev_ff;
   logic [BDFM_EV_W-1:0] int_w1c;
   logic irq_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic [31:0] prdata_ff;
   logic [31:0] rd_data;
   logic rd_hit;
   logic apb_done;
   logic apb_wr;
   logic [31:0] status_word;

   assign gate_on = {gate_ls_ff, gate_hs_ff};
   assign short_dis = short_threshold_input;
   assign luv_enter = logic_supply_rail_below_off & ~luv_ff;

   // ---------------- short detection ----------------

   // per-fet on-time counter; restarts whenever the fet turns off
   always_ff @(posedge clk) begin
      for (int i = 0; i < BDFM_NFET; i++) begin
         if (rst || !gate_on[i]) begin
            blank_cnt_ff[i] <= '0;
         end else begin
            blank_cnt_ff[i] <= sat_inc(blank_cnt_ff[i]);
         end
      end
   end

   always_comb begin
      for (int i = 0; i < BDFM_NFET; i++) begin
         short_det[i] = gate_on[i] && (blank_cnt_ff[i] >= blank_ff) && vds_over[i] && !short_dis;
      end
   end

   // a pending detection wins over the host reset pulse
   always_ff @(posedge clk) begin
      if (rst) begin
         short_ff <= '0;
      end else if (luv_enter || short_dis) begin
         short_ff <= '0;
      end else begin
         short_ff <= (short_ff & {BDFM_NFET{reset_n}}) | short_det;
      end
   end

   assign short_eff = short_ff & {BDFM_NFET{~short_dis}};

   // ---------------- supply and temperature states ----------------

   always_ff @(posedge clk) begin
      if (rst) begin
         luv_ff <= 1'b1;
      end else if (logic_supply_rail_below_off) begin
         luv_ff <= 1'b1;
      end else if (logic_supply_rail_above_on) begin
         luv_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         guv_ff <= 1'b1;
      end else if (luv_enter) begin
         guv_ff <= 1'b0;
      end else if (gate_supply_rail_below_off) begin
         guv_ff <= 1'b1;
      end else if (gate_supply_rail_above_on) begin
         guv_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ot_ff <= 1'b0;
      end else if (luv_enter) begin
         ot_ff <= 1'b0;
      end else if (overtemp_hot) begin
         ot_ff <= 1'b1;
      end else if (overtemp_recovered) begin
         ot_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         buv_ff <= '0;
      end else if (luv_enter) begin
         buv_ff <= '0;
      end else begin
         buv_ff <= (buv_ff & {BDFM_NPH{reset_n}}) | boot_timeout;
      end
   end

   // overtemperature is deliberately absent: it only reports
   assign out_dis = (|short_eff) | guv_ff | luv_ff | (|buv_ff);

   // ---------------- bootstrap management ----------------

   always_comb begin
      for (int p = 0; p < BDFM_NPH; p++) begin
         nxt_boot_st[p] = boot_st_ff[p];
         nxt_chg_cnt[p] = chg_cnt_ff[p];
         charge_req[p] = 1'b0;
         boot_timeout[p] = 1'b0;
         unique case (boot_st_ff[p])
            BDFM_BOOT_IDLE: begin
               nxt_chg_cnt[p] = '0;
               if (hs_req[p]) begin
                  nxt_boot_st[p] = boot_above_on[p] ? BDFM_BOOT_READY : BDFM_BOOT_CHARGE;
               end
            end
            BDFM_BOOT_CHARGE: begin
               charge_req[p] = 1'b1;
               nxt_chg_cnt[p] = sat_inc(chg_cnt_ff[p]);
               if (!hs_req[p]) begin
                  nxt_boot_st[p] = BDFM_BOOT_IDLE;
               end else if (boot_above_on[p]) begin
                  nxt_boot_st[p] = BDFM_BOOT_READY;
               end else if (chg_cnt_ff[p] >= chg_tmo_ff) begin
                  boot_timeout[p] = 1'b1;
                  nxt_boot_st[p] = BDFM_BOOT_IDLE;
               end
            end
            BDFM_BOOT_READY: begin
               nxt_chg_cnt[p] = '0;
               if (!hs_req[p]) begin
                  nxt_boot_st[p] = BDFM_BOOT_IDLE;
               end else if (boot_below_off[p]) begin
                  nxt_boot_st[p] = BDFM_BOOT_CHARGE;
               end
            end
         endcase
         // a disabled bridge abandons any charge cycle so it restarts cleanly
         if (out_dis) begin
            nxt_boot_st[p] = BDFM_BOOT_IDLE;
            charge_req[p] = 1'b0;
            boot_timeout[p] = 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      for (int p = 0; p < BDFM_NPH; p++) begin
         if (rst) begin
            boot_st_ff[p] <= BDFM_BOOT_IDLE;
            chg_cnt_ff[p] <= '0;
         end else begin
            boot_st_ff[p] <= nxt_boot_st[p];
            chg_cnt_ff[p] <= nxt_chg_cnt[p];
         end
      end
   end

   // ---------------- gate drives ----------------

   always_comb begin
      for (int p = 0; p < BDFM_NPH; p++) begin
         nxt_gate_hs[p] = hs_req[p] && (boot_st_ff[p] == BDFM_BOOT_READY) && !short_eff[p] && !out_dis;
         nxt_gate_ls[p] = (ls_req[p] || charge_req[p]) && !short_eff[p + BDFM_NPH] && !out_dis;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         gate_hs_ff <= '0;
         gate_ls_ff <= '0;
      end else begin
         gate_hs_ff <= nxt_gate_hs;
         gate_ls_ff <= nxt_gate_ls;
      end
   end

   // ---------------- fault flags ----------------

   // a high flag means released: the external pull-up sets the level
   assign flag_a_high = ot_ff | guv_ff | luv_ff | (|buv_ff);
   assign flag_b_high = (|short_eff) | guv_ff | luv_ff | (|buv_ff);

   always_ff @(posedge clk) begin
      if (rst) begin
         fault_flag_a_oe_ff <= 1'b0;
         fault_flag_b_oe_ff <= 1'b0;
      end else begin
         fault_flag_a_oe_ff <= ~flag_a_high;
         fault_flag_b_oe_ff <= ~flag_b_high;
      end
   end

   // ---------------- interrupts ----------------

   assign ev_cur = {(|buv_ff), luv_ff, guv_ff, ot_ff, (|short_eff)};

   always_ff @(posedge clk) begin
      if (rst) begin
         ev_prev_ff <= BDFM_EV_PREV_RST;
      end else begin
         ev_prev_ff <= ev_cur;
      end
   end

   assign int_w1c = (apb_wr && paddr == BDFM_ADDR_INT_STAT) ? pwdata[BDFM_EV_W-1:0] : '0;
   // a new event in the clearing cycle survives the write
   assign nxt_int_stat = (int_stat_ff & ~int_w1c) | (ev_cur & ~ev_prev_ff);

   always_ff @(posedge clk) begin
      if (rst) begin
         int_stat_ff <= BDFM_INT_STAT_RST;
         irq_ff <= 1'b0;
      end else begin
         int_stat_ff <= nxt_int_stat;
         irq_ff <= |(nxt_int_stat & int_mask_ff);
      end
   end

   // ---------------- apb slave ----------------

   // one wait state so that pready and prdata leave flip-flops
   assign apb_done = psel && penable && pready_ff;
   assign apb_wr = apb_done && pwrite;

   assign status_word = {22'h000000, short_dis, buv_ff, luv_ff, guv_ff, ot_ff, short_eff};

   always_comb begin
      rd_data = '0;
      rd_hit = 1'b1;
      unique case (paddr)
         BDFM_ADDR_STATUS: rd_data = status_word;
         BDFM_ADDR_INT_STAT: rd_data = {27'h0000000, int_stat_ff};
         BDFM_ADDR_INT_MASK: rd_data = {27'h0000000, int_mask_ff};
         BDFM_ADDR_BLANK: rd_data = {16'h0000, blank_ff};
         BDFM_ADDR_CHG_TMO: rd_data = {16'h0000, chg_tmo_ff};
         BDFM_ADDR_GATE: rd_data = {28'h0000000, gate_ls_ff, gate_hs_ff};
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= '0;
      end else begin
         pready_ff <= psel && penable && !pready_ff;
         pslverr_ff <= psel && penable && !pready_ff && !rd_hit;
         if (psel && penable && !pready_ff && !pwrite) begin
            prdata_ff <= rd_data;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         int_mask_ff <= BDFM_INT_MASK_RST;
         blank_ff <= BDFM_BLANK_RST;
         chg_tmo_ff <= BDFM_CHG_TMO_RST;
      end else if (apb_wr) begin
         if (paddr == BDFM_ADDR_INT_MASK) begin
            int_mask_ff <= pwdata[BDFM_EV_W-1:0];
         end
         if (paddr == BDFM_ADDR_BLANK) begin
            blank_ff <= pwdata[BDFM_CNT_W-1:0];
         end
         if (paddr == BDFM_ADDR_CHG_TMO) begin
            chg_tmo_ff <= pwdata[BDFM_CNT_W-1:0];
         end
      end
   end

   assign gate_hs = gate_hs_ff;
   assign gate_ls = gate_ls_ff;
   assign fault_flag_a_out = 1'b0;
   assign fault_flag_b_out = 1'b0;
   assign fault_flag_a_oe = fault_flag_a_oe_ff;
   assign fault_flag_b_oe = fault_flag_b_oe_ff;
   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign irq = irq_ff;

endmodule : bdfm_fault_monitor

/* bdfm_properties.sv */
// port-level assertions on the fault monitor, bound into every instance
`timescale 1ns/1ps
module bdfm_properties
   import bdfm_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic overtemp_hot,
   input wire logic overtemp_recovered,
   input wire logic gate_supply_rail_below_off,
   input wire logic logic_supply_rail_below_off,
   input wire logic [BDFM_NPH-1:0] gate_hs,
   input wire logic [BDFM_NPH-1:0] gate_ls,
   input wire logic fault_flag_a_out,
   input wire logic fault_flag_a_oe,
   input wire logic fault_flag_b_out,
   input wire logic fault_flag_b_oe,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence apb_setup;
      psel && !penable;
   endsequence
   sequence apb_access;
      psel && penable;
   endsequence
   a_flag_pins_low: assert property (!fault_flag_a_out && !fault_flag_b_out)
      else $error("open drain flag driven high");
   a_ot_flag_up: assert property (overtemp_hot && !overtemp_recovered |-> ##2 !fault_flag_a_oe)
      else $error("overtemperature did not raise flag a");
   a_gate_uv_flags: assert property (gate_supply_rail_below_off |-> ##2 (!fault_flag_a_oe && !fault_flag_b_oe))
      else $error("gate supply undervoltage flags wrong");
   a_logic_uv_flags: assert property (logic_supply_rail_below_off |-> ##2 (!fault_flag_a_oe && !fault_flag_b_oe))
      else $error("logic supply undervoltage flags wrong");
   a_logic_uv_gates: assert property (logic_supply_rail_below_off |-> ##2 (gate_hs == 2'h0 && gate_ls == 2'h0))
      else $error("gates on under logic supply undervoltage");
   // flag b high marks exactly the faults that disable outputs
   a_disable_gates_off: assert property (!fault_flag_b_oe |-> (gate_hs == 2'h0 && gate_ls == 2'h0))
      else $error("gates on while a disabling fault is shown");
   a_apb_wait: assert property (apb_setup ##1 apb_access |-> !pready ##1 pready)
      else $error("apb answer not after one wait state");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
endmodule : bdfm_properties

bind bdfm_fault_monitor bdfm_properties u_props (.clk(clk), .rst(rst), .overtemp_hot(overtemp_hot),
   .overtemp_recovered(overtemp_recovered), .gate_supply_rail_below_off(gate_supply_rail_below_off),
   .logic_supply_rail_below_off(logic_supply_rail_below_off), .gate_hs(gate_hs), .gate_ls(gate_ls),
   .fault_flag_a_out(fault_flag_a_out), .fault_flag_a_oe(fault_flag_a_oe), .fault_flag_b_out(fault_flag_b_out),
   .fault_flag_b_oe(fault_flag_b_oe), .psel(psel), .penable(penable), .pready(pready));

/* bdfm_host_model.sv */
// host controller: pull-ups on the fault flags and a short reset pulse on request
`timescale 1ns/1ps
module bdfm_host_model #(
   parameter int RES_PULSE = 3
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic clear_req,
   input wire logic fault_flag_a_oe,
   input wire logic fault_flag_b_oe,
   output logic reset_n,
   output logic flag_a,
   output logic flag_b
);
   logic [3:0] pulse_ff;
   // pull-up makes a released flag read high
   assign flag_a = !fault_flag_a_oe;
   assign flag_b = !fault_flag_b_oe;
   always_ff @(posedge clk) begin
      if (rst)
         pulse_ff <= 4'h0;
      else if (clear_req && pulse_ff == 4'h0)
         pulse_ff <= 4'(RES_PULSE);
      else if (pulse_ff != 4'h0)
         pulse_ff <= pulse_ff - 4'h1;
   end
   // kept short so the device would not fall into sleep
   assign reset_n = (pulse_ff == 4'h0);
endmodule : bdfm_host_model

/* testbench.sv */
// self-checking bench of the fault monitor with a host model
`timescale 1ns/1ps
module testbench
   import bdfm_pkg::*;
;
   logic clk, rst, reset_n, short_threshold_input, overtemp_hot, overtemp_recovered, clear_req;
   logic gate_supply_rail_below_off, gate_supply_rail_above_on, flag_a, flag_b, err;
   logic logic_supply_rail_below_off, logic_supply_rail_above_on;
   logic psel, penable, pwrite, pready, pslverr, irq;
   logic fault_flag_a_out, fault_flag_a_oe, fault_flag_b_out, fault_flag_b_oe;
   logic [1:0] hs_req, ls_req, boot_above_on, boot_below_off, gate_hs, gate_ls;
   logic [3:0] vds_over;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0] ra [5] = '{BDFM_ADDR_INT_STAT, BDFM_ADDR_INT_MASK, BDFM_ADDR_BLANK, BDFM_ADDR_CHG_TMO, BDFM_ADDR_GATE};
   logic [31:0] re [5] = '{32'(BDFM_INT_STAT_RST), 32'(BDFM_INT_MASK_RST), 32'(BDFM_BLANK_RST),
      32'(BDFM_CHG_TMO_RST), 32'h0};
   int fails, comparisons;

   bdfm_fault_monitor DUT (.clk(clk), .rst(rst), .reset_n(reset_n), .hs_req(hs_req), .ls_req(ls_req),
      .vds_over(vds_over), .short_threshold_input(short_threshold_input),
      .gate_supply_rail_below_off(gate_supply_rail_below_off), .gate_supply_rail_above_on(gate_supply_rail_above_on),
      .logic_supply_rail_below_off(logic_supply_rail_below_off),
      .logic_supply_rail_above_on(logic_supply_rail_above_on), .overtemp_hot(overtemp_hot),
      .overtemp_recovered(overtemp_recovered), .boot_above_on(boot_above_on), .boot_below_off(boot_below_off),
      .gate_hs(gate_hs), .gate_ls(gate_ls), .fault_flag_a_out(fault_flag_a_out), .fault_flag_a_oe(fault_flag_a_oe),
      .fault_flag_b_out(fault_flag_b_out), .fault_flag_b_oe(fault_flag_b_oe), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq(irq));
   bdfm_host_model u_host (.clk(clk), .rst(rst), .clear_req(clear_req), .fault_flag_a_oe(fault_flag_a_oe),
      .fault_flag_b_oe(fault_flag_b_oe), .reset_n(reset_n), .flag_a(flag_a), .flag_b(flag_b));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // the extra ns lets registered outputs settle before they are looked at
   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task flags(input logic [1:0] e);
      chk("flags", {30'h0, e}, {30'h0, flag_a, flag_b});
   endtask : flags
   task gates(input logic [3:0] e);
      chk("gates", {28'h0, e}, {28'h0, gate_ls, gate_hs});
   endtask : gates
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask : apb
   task close_out;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : close_out

   initial begin
      tick(4000);
      fails++;
      close_out;
   end

   initial begin
      {psel, penable, pwrite, paddr, pwdata, hs_req, ls_req, vds_over, boot_above_on, boot_below_off} = '0;
      {short_threshold_input, overtemp_hot, overtemp_recovered, clear_req} = '0;
      {gate_supply_rail_above_on, logic_supply_rail_above_on} = '0;
      {rst, gate_supply_rail_below_off, logic_supply_rail_below_off} = 3'h7;
      tick(20);
      rst <= 1'b0;
      tick(4);
      flags(2'h3);
      logic_supply_rail_below_off <= 1'b0;
      logic_supply_rail_above_on <= 1'b1;
      tick(4);
      flags(2'h3);
      gate_supply_rail_below_off <= 1'b0;
      gate_supply_rail_above_on <= 1'b1;
      tick(4);
      flags(2'h0);
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, ra[i], 32'h0);
         chk("reset value", re[i], rd);
      end
      apb(1'b0, 8'h18, 32'h0);
      chk("slverr", 32'h1, {31'h0, err});
      chk("slverr data", 32'h0, rd);
      apb(1'b1, BDFM_ADDR_BLANK, 32'h4);
      apb(1'b1, BDFM_ADDR_CHG_TMO, 32'hA);
      apb(1'b0, BDFM_ADDR_CHG_TMO, 32'h0);
      chk("timeout reg", 32'hA, rd);
      hs_req <= 2'h1;
      tick(3);
      gates(4'h4);
      boot_above_on <= 2'h1;
      tick(3);
      gates(4'h1);
      boot_below_off <= 2'h1;
      boot_above_on <= 2'h0;
      tick(3);
      gates(4'h4);
      tick(14);
      flags(2'h3);
      gates(4'h0);
      boot_below_off <= 2'h0;
      hs_req <= 2'h0;
      tick(4);
      flags(2'h3);
      apb(1'b0, BDFM_ADDR_STATUS, 32'h0);
      chk("status", 32'h80, rd);
      apb(1'b0, BDFM_ADDR_INT_STAT, 32'h0);
      chk("event", 32'h10, rd);
      chk("masked irq", 32'h0, {31'h0, irq});
      apb(1'b1, BDFM_ADDR_INT_MASK, 32'h1F);
      tick(2);
      chk("irq", 32'h1, {31'h0, irq});
      clear_req <= 1'b1;
      tick(1);
      clear_req <= 1'b0;
      tick(7);
      flags(2'h0);
      apb(1'b1, BDFM_ADDR_INT_STAT, 32'h1F);
      tick(2);
      chk("irq cleared", 32'h0, {31'h0, irq});
      ls_req <= 2'h1;
      overtemp_hot <= 1'b1;
      tick(3);
      flags(2'h2);
      gates(4'h4);
      overtemp_hot <= 1'b0;
      tick(3);
      flags(2'h2);
      overtemp_recovered <= 1'b1;
      tick(3);
      flags(2'h0);
      overtemp_recovered <= 1'b0;
      ls_req <= 2'h0;
      // let the low side turn off first: a trip while it is still on is a real short
      tick(1);
      vds_over <= 4'h4;
      tick(7);
      flags(2'h0);
      ls_req <= 2'h1;
      tick(3);
      flags(2'h0);
      tick(6);
      flags(2'h1);
      gates(4'h0);
      vds_over <= 4'h0;
      tick(4);
      flags(2'h1);
      overtemp_hot <= 1'b1;
      tick(3);
      flags(2'h3);
      overtemp_hot <= 1'b0;
      overtemp_recovered <= 1'b1;
      tick(3);
      flags(2'h1);
      overtemp_recovered <= 1'b0;
      logic_supply_rail_below_off <= 1'b1;
      tick(3);
      flags(2'h3);
      logic_supply_rail_below_off <= 1'b0;
      tick(5);
      flags(2'h0);
      gates(4'h4);
      short_threshold_input <= 1'b1;
      vds_over <= 4'h4;
      tick(12);
      flags(2'h0);
      gates(4'h4);
      apb(1'b0, BDFM_ADDR_STATUS, 32'h0);
      chk("status", 32'h200, rd);
      vds_over <= 4'h0;
      gate_supply_rail_below_off <= 1'b1;
      tick(3);
      flags(2'h3);
      gates(4'h0);
      gate_supply_rail_below_off <= 1'b0;
      tick(4);
      flags(2'h0);
      close_out;
   end
endmodule : testbench
